// file: shared/acq_consts.vh
// Behaviour
// (RQ1) samples queue in FIFO, host reads port
// (RQ2) 12-bit reads: sample high, channel low
// (RQ3) 16-bit reads: full sample, no tag
// (RQ4) channel register: single or scan end
// (RQ5) low nibble mux, high nibble expansion
// (RQ6) channel readback high nibble zero unscanned
// (RQ7) scanning: high nibble current, steps per trigger
// (RQ8) gain code drives amplifier gain
// (RQ9) status byte: busy, full, half, empty, gain
// (RQ10) busy low until sample enters FIFO
// (RQ11) full flag low when FIFO full
// (RQ12) mode register: pretrigger, source, pacer, scan
// (RQ13) three trigger selections, external overrides pacer
// (RQ14) trigger choice independent of interrupts
// (RQ15) any soft trigger write fires once
// (RQ16) first interrupt: end or half full
// (RQ17) second interrupt: tick or external fall
// (RQ18) FIFO disable bit, toggle resets FIFO
// (RQ19) interrupt held until clear write
// (RQ20) mode readback: enable, selects, mode bits
// (RQ21) extended lines, outputs read in high nibble
// (RQ22) scan runs zero to last, wraps
// (RQ23) conversion starts on trigger rising edge
// (RQ24) extended output pin modes one to three
// (RQ25) control registers reset to zero
`ifndef ACQ_CONSTS_VH
`define ACQ_CONSTS_VH
`define OFS_DATA      8'h00
`define OFS_EXT       8'h04
`define OFS_CHAN      8'h06
`define OFS_GAIN      8'h08
`define OFS_MODE      8'h0A
`define OFS_IRQCTL    8'h0C
`define OFS_SOFTTRIG  8'h0E
`define OFS_IRQCLR    8'h48
`define MODE_SCAN     0
`define MODE_PACER    1
`define MODE_EXTSRC   2
`define MODE_PRETRIG  3
`define IRQ_SEL0      0
`define IRQ_SEL1      1
`define IRQ_FIFO_DIS  2
`define ST_BUSY_N     7
`define ST_FULL_N     6
`define ST_HALF_N     5
`define ST_EMPTY_N    4
`define RST_CHAN      8'h00
`define RST_GAIN      3'h0
`define RST_MODE      4'h0
`define RST_IRQCTL    3'h0
`define EXT_MODE_IN   2'h1
`define EXT_MODE_OUT  2'h2
`define EXT_MODE_CHAN 2'h3
`define FIFO_WIDTH    20
`define FIFO_DEPTH    8
`endif

// file: design/sample_fifo.v
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,
  input  wire             rst,
  input  wire             flush,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             full,
  output wire             half,
  output wire             empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  // while flushed the source is never stalled: samples are discarded
  assign in_ready  = (count != DEPTH[AW:0]) || flush;
  assign push      = in_valid && in_ready && !flush;
  assign out_valid = (count != {(AW+1){1'b0}}) && !flush;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr];
  assign full      = (count == DEPTH[AW:0]);
  assign half      = (count >= (DEPTH[AW:0] >> 1));
  assign empty     = (count == {(AW+1){1'b0}});

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (rst || flush) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: design/trigger_select.v
`timescale 1ns/10ps
`include "acq_consts.vh"
`default_nettype none
module trigger_select (
  input  wire       clk,
  input  wire       rst,
  input  wire [3:0] mode,
  input  wire       soft_pulse,
  input  wire       pacer_tick,
  input  wire       external_trigger_in,
  output reg        trigger,
  output wire       ext_fall
);
  reg  ext_prev;
  reg  pacer_prev;
  wire ext_rise;
  wire pacer_rise;

  assign ext_rise   = external_trigger_in && !ext_prev;
  assign ext_fall   = !external_trigger_in && ext_prev;
  assign pacer_rise = pacer_tick && !pacer_prev;

  always @(posedge clk) begin
    if (rst) begin
      ext_prev   <= 1'b0;
      pacer_prev <= 1'b0;
    end else begin
      ext_prev   <= external_trigger_in;
      pacer_prev <= pacer_tick;
    end
  end

  // source choice looks only at mode bits, never at interrupt selects [RQ14]
  always @* begin
    if (mode[`MODE_EXTSRC]) begin
      trigger = ext_rise; // [RQ13] [RQ23]
    end else if (mode[`MODE_PACER]) begin
      trigger = pacer_rise; // [RQ13] [RQ23]
    end else begin
      trigger = soft_pulse; // [RQ13] [RQ15]
    end
  end
endmodule
`default_nettype wire

// file: design/acq_control.v
`timescale 1ns/10ps
`include "acq_consts.vh"
`default_nettype none
module acq_control (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire [7:0]  io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [15:0] io_wdata,
  output reg  [15:0] io_rdata,
  output reg         io_rd_ack,
  input  wire        variant_16bit,
  output reg         conv_start,
  input  wire        adc_done,
  input  wire [15:0] adc_result,
  output wire [3:0]  mux_channel_bits,
  output wire [3:0]  expansion_channel,
  output wire [2:0]  gain_code,
  output wire        pretrigger_enable,
  input  wire        pacer_tick,
  input  wire        external_trigger_in,
  output wire        bus_irq,
  output wire        first_interrupt,
  output wire        second_interrupt,
  input  wire [1:0]  ext_mode,
  input  wire [3:0]  extended_input_lines,
  output wire [3:0]  extended_output_lines,
  output wire        extended_output_oe
);
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_HOLD = 2'b10;

  ////////////////////////////////////////////////////////////////////
  // register state
  reg  [7:0]  chan_setting;
  reg  [2:0]  gain;
  reg  [3:0]  mode;
  reg  [2:0]  irq_ctl;
  reg  [3:0]  ext_out;
  reg  [3:0]  scan_current_channel;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [3:0]  sample_channel_tag;
  reg  [15:0] sample_value;
  reg         irq_flag0;
  reg         irq_flag1;
  reg         half_prev;
  wire        scan_enable;
  wire        fifo_disable;
  wire        wr_data_hit;
  wire        soft_pulse;
  wire        clear_pulse;
  wire        trigger;
  wire        ext_fall;
  wire        fifo_in_ready;
  wire        fifo_out_valid;
  wire        fifo_full;
  wire        fifo_half;
  wire        fifo_empty;
  wire        fifo_pop;
  wire        push_done;
  wire        fifo_disable_n;
  wire [19:0] fifo_out;
  wire        busy_n;
  wire        event0;
  wire        event1;

  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = io_wr && (addr == ofs);
    end
  endfunction

  assign scan_enable    = mode[`MODE_SCAN];
  assign fifo_disable   = irq_ctl[`IRQ_FIFO_DIS];
  assign fifo_disable_n = !fifo_disable;
  assign soft_pulse     = wr_hit(io_addr, `OFS_SOFTTRIG); // [RQ15]
  assign clear_pulse    = wr_hit(io_addr, `OFS_IRQCLR);   // [RQ19]
  assign wr_data_hit    = io_rd && (io_addr == `OFS_DATA);
  // host moves samples only by reading the data port [RQ1]
  assign fifo_pop       = wr_data_hit && fifo_out_valid;

  ////////////////////////////////////////////////////////////////////
  // control register writes
  always @(posedge core_clk) begin
    if (sys_rst) begin
      chan_setting <= `RST_CHAN;   // [RQ25]
      gain         <= `RST_GAIN;   // [RQ25]
      mode         <= `RST_MODE;   // [RQ25]
      irq_ctl      <= `RST_IRQCTL; // [RQ18] [RQ25]
      ext_out      <= 4'h0;
    end else begin
      if (io_wr && io_addr == `OFS_CHAN) begin
        chan_setting <= io_wdata[7:0]; // [RQ4]
      end else if (io_wr && io_addr == `OFS_GAIN) begin
        gain <= io_wdata[2:0]; // [RQ8]
      end else if (io_wr && io_addr == `OFS_MODE) begin
        mode <= io_wdata[3:0]; // [RQ12]
      end else if (io_wr && io_addr == `OFS_IRQCTL) begin
        irq_ctl <= io_wdata[2:0]; // [RQ16] [RQ17] [RQ18]
      end else if (io_wr && io_addr == `OFS_EXT) begin
        ext_out <= io_wdata[3:0]; // [RQ21]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // trigger source
  trigger_select u_trig (
    .clk                 (core_clk),
    .rst                 (sys_rst),
    .mode                (mode),
    .soft_pulse          (soft_pulse),
    .pacer_tick          (pacer_tick),
    .external_trigger_in (external_trigger_in),
    .trigger             (trigger),
    .ext_fall            (ext_fall)
  );

  ////////////////////////////////////////////////////////////////////
  // automatic scan: every trigger steps the channel, even one that
  // arrives while a conversion is still pending and is dropped
  always @(posedge core_clk) begin
    if (sys_rst || !scan_enable) begin
      scan_current_channel <= 4'h0; // [RQ22]
    end else if (trigger) begin
      if (scan_current_channel >= chan_setting[3:0]) begin
        scan_current_channel <= 4'h0; // [RQ22]
      end else begin
        scan_current_channel <= scan_current_channel + 4'h1; // [RQ7]
      end
    end
  end

  assign mux_channel_bits  = scan_enable ? scan_current_channel
                                         : chan_setting[3:0]; // [RQ4] [RQ5]
  assign expansion_channel = chan_setting[7:4]; // [RQ5]
  assign gain_code         = gain;              // [RQ8]
  assign pretrigger_enable = mode[`MODE_PRETRIG];

  ////////////////////////////////////////////////////////////////////
  // conversion sequencer; a full FIFO stalls it, so triggers seen
  // meanwhile are lost, which the full flag warns of
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (trigger) begin
          next_state = ST_CONV; // [RQ23]
        end
      end
      ST_CONV: begin
        if (adc_done) begin
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (fifo_in_ready) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state              <= ST_IDLE;
      conv_start         <= 1'b0;
      sample_channel_tag <= 4'h0;
      sample_value       <= 16'h0000;
    end else begin
      state      <= next_state;
      conv_start <= (state == ST_IDLE) && trigger; // [RQ23]
      if (state == ST_IDLE && trigger) begin
        sample_channel_tag <= mux_channel_bits;
      end
      if (state == ST_CONV && adc_done) begin
        sample_value <= adc_result;
      end
    end
  end

  // busy reads low until the sample has gone into the FIFO [RQ10]
  assign busy_n    = (state == ST_IDLE);
  assign push_done = (state == ST_HOLD) && fifo_in_ready;

  ////////////////////////////////////////////////////////////////////
  // sample buffer; disable bit holds it flushed [RQ18]
  sample_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (3)
  ) u_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .flush     (fifo_disable),
    .in_valid  (state == ST_HOLD), // [RQ1]
    .in_ready  (fifo_in_ready),
    .in_data   ({sample_value, sample_channel_tag}),
    .out_valid (fifo_out_valid),
    .out_ready (wr_data_hit),
    .out_data  (fifo_out),
    .full      (fifo_full),
    .half      (fifo_half),
    .empty     (fifo_empty)
  );

  ////////////////////////////////////////////////////////////////////
  // interrupts; a new event in the clear cycle keeps the flag set
  assign event0 = irq_ctl[`IRQ_SEL0] ? (fifo_half && !half_prev && fifo_disable_n)
                                     : push_done; // [RQ16]
  assign event1 = irq_ctl[`IRQ_SEL1] ? ext_fall : pacer_tick; // [RQ17]

  always @(posedge core_clk) begin
    if (sys_rst) begin
      irq_flag0 <= 1'b0;
      irq_flag1 <= 1'b0;
      half_prev <= 1'b0;
    end else begin
      half_prev <= fifo_half;
      if (event0) begin
        irq_flag0 <= 1'b1;
      end else if (clear_pulse) begin
        irq_flag0 <= 1'b0; // [RQ19]
      end
      if (event1) begin
        irq_flag1 <= 1'b1;
      end else if (clear_pulse) begin
        irq_flag1 <= 1'b0; // [RQ19]
      end
    end
  end

  assign first_interrupt  = irq_flag0;
  assign second_interrupt = irq_flag1;
  assign bus_irq          = irq_flag0 || irq_flag1; // [RQ19]

  ////////////////////////////////////////////////////////////////////
  // extended output pins
  assign extended_output_oe    = (ext_mode == `EXT_MODE_OUT) ||
                                 (ext_mode == `EXT_MODE_CHAN); // [RQ24]
  assign extended_output_lines = (ext_mode == `EXT_MODE_CHAN) ? chan_setting[7:4]
                                                              : ext_out; // [RQ24]

  ////////////////////////////////////////////////////////////////////
  // register reads, answered one cycle after the strobe
  always @(posedge core_clk) begin
    if (sys_rst) begin
      io_rdata  <= 16'h0000;
      io_rd_ack <= 1'b0;
    end else begin
      io_rd_ack <= io_rd;
      if (!io_rd) begin
        io_rdata <= io_rdata;
      end else if (io_addr == `OFS_DATA) begin
        if (variant_16bit) begin
          io_rdata <= fifo_out[19:4]; // [RQ3]
        end else begin
          io_rdata <= {fifo_out[15:4], fifo_out[3:0]}; // [RQ2]
        end
      end else if (io_addr == `OFS_EXT) begin
        io_rdata <= {8'h00, ext_out, extended_input_lines}; // [RQ21]
      end else if (io_addr == `OFS_CHAN) begin
        io_rdata <= {8'h00, scan_current_channel,
                     chan_setting[3:0]}; // [RQ6] [RQ7]
      end else if (io_addr == `OFS_GAIN) begin
        io_rdata <= {8'h00, busy_n, !fifo_full, !fifo_half,
                     !fifo_empty, 1'b0, gain}; // [RQ9] [RQ10] [RQ11]
      end else if (io_addr == `OFS_MODE) begin
        io_rdata <= {8'h00, 1'b0, irq_ctl, mode}; // [RQ20]
      end else begin
        io_rdata <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/acq_control_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module acq_control_asserts (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [7:0]  io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [15:0] io_rdata,
  input wire logic        io_rd_ack,
  input wire logic        conv_start,
  input wire logic [3:0]  expansion_channel,
  input wire logic [2:0]  gain_code,
  input wire logic        pretrigger_enable,
  input wire logic        bus_irq,
  input wire logic        first_interrupt,
  input wire logic        second_interrupt,
  input wire logic [1:0]  ext_mode,
  input wire logic [3:0]  extended_output_lines,
  input wire logic        extended_output_oe
);
  // clear strobe decoded once so both flag checks see the same event
  wire clr_wr;
  assign clr_wr = io_wr && io_addr == 8'h48;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_read_req;
    io_rd;
  endsequence
  sequence s_read_ans;
    io_rd_ack;
  endsequence
  a_read_answer: assert property (s_read_req |=> s_read_ans)
    else $error("read not answered next cycle");
  a_no_stray_ack: assert property (!io_rd |=> !io_rd_ack)
    else $error("ack without read");
  a_rdata_holds: assert property ($changed(io_rdata) |-> io_rd_ack)
    else $error("read data moved without ack");
  a_conv_single_pulse: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  a_irq_line_or: assert property (bus_irq == (first_interrupt | second_interrupt))
    else $error("bus irq not the or of flags");
  a_flag0_held: assert property (first_interrupt && !clr_wr |=> first_interrupt)
    else $error("first flag dropped without clear");
  a_flag1_held: assert property (second_interrupt && !clr_wr |=> second_interrupt)
    else $error("second flag dropped without clear");
  a_gain_by_write: assert property ($changed(gain_code) |-> $past(io_wr && io_addr == 8'h08))
    else $error("gain moved without write");
  a_pretrig_by_write: assert property ($changed(pretrigger_enable) |-> $past(io_wr && io_addr == 8'h0A))
    else $error("pretrigger moved without write");
  a_oe_by_mode: assert property (extended_output_oe == (ext_mode == 2'h2 || ext_mode == 2'h3))
    else $error("output enable wrong for mode");
  a_chan_on_pins: assert property (ext_mode == 2'h3 |-> extended_output_lines == expansion_channel)
    else $error("pins not showing channel high nibble");
endmodule
bind acq_control acq_control_asserts chk_u (
  .core_clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_rdata, .io_rd_ack, .conv_start, .expansion_channel,
  .gain_code, .pretrigger_enable, .bus_irq, .first_interrupt, .second_interrupt, .ext_mode,
  .extended_output_lines, .extended_output_oe
);
`default_nettype wire

// file: bench/adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_model (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        conv_start,
  input wire logic [15:0] value,
  input wire logic [3:0]  lat,
  output var logic        adc_done,
  output var logic [15:0] adc_result
);
  logic       busy;
  logic [3:0] cnt;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      busy       <= 1'b0;
      cnt        <= 4'h0;
      adc_done   <= 1'b0;
      adc_result <= 16'hFFFF;
    end else begin
      adc_done <= 1'b0;
      // result is only valid with done; invert after so stale data is never mistaken
      if (adc_done) begin
        adc_result <= ~adc_result;
      end
      if (conv_start) begin
        busy <= 1'b1;
        cnt  <= lat;
      end else if (busy) begin
        if (cnt == 4'h0) begin
          busy       <= 1'b0;
          adc_done   <= 1'b1;
          adc_result <= value;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: bench/test_adc_acquisition_control.sv
`timescale 1ns/10ps
`default_nettype none
module test_adc_acquisition_control;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  io_addr = 8'h00;
  logic        io_wr = 1'b0;
  logic        io_rd = 1'b0;
  logic [15:0] io_wdata = 16'h0000;
  logic [15:0] io_rdata;
  logic        io_rd_ack;
  logic        variant_16bit = 1'b0;
  logic        conv_start;
  logic        adc_done;
  logic [15:0] adc_result;
  logic [3:0]  mux_channel_bits;
  logic [3:0]  expansion_channel;
  logic [2:0]  gain_code;
  logic        pretrigger_enable;
  logic        pacer_tick = 1'b0;
  logic        external_trigger_in = 1'b0;
  logic        bus_irq;
  logic        first_interrupt;
  logic        second_interrupt;
  logic [1:0]  ext_mode = 2'h1;
  logic [3:0]  extended_input_lines = 4'h0;
  logic [3:0]  extended_output_lines;
  logic        extended_output_oe;
  logic [15:0] value = 16'h0000;
  logic [3:0]  lat = 4'h0;
  logic [3:0]  cur;
  logic [15:0] g;
  int          num_errors = 0;
  int          checks_done = 0;
  int          i;
  int          k;
  always #5 core_clk = ~core_clk;
  acq_control dut_u (
    .core_clk, .sys_rst, .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata, .io_rd_ack, .variant_16bit,
    .conv_start, .adc_done, .adc_result, .mux_channel_bits, .expansion_channel, .gain_code,
    .pretrigger_enable, .pacer_tick, .external_trigger_in, .bus_irq, .first_interrupt, .second_interrupt,
    .ext_mode, .extended_input_lines, .extended_output_lines, .extended_output_oe
  );
  adc_model adc_u (.core_clk, .sys_rst, .conv_start, .value, .lat, .adc_done, .adc_result);
  ////////////////////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task chkb(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask
  // settles one step past the edge so checks see the write's effect
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge core_clk);
    io_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge core_clk);
    io_rd <= 1'b0;
    #1;
    chkb(io_rd_ack, 1'b1);
    chk(io_rdata, e);
  endtask
  task conv(input logic [15:0] d, input logic [3:0] l);
    @(posedge core_clk);
    value <= d;
    lat   <= l;
    wr(8'h0E, 16'h5A5A);
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      #1;
      if (adc_done === 1'b1) break;
    end
    if (i == 40) begin
      num_errors++;
      test_done;
    end
    repeat (3) @(posedge core_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(8'h06, 16'h0000);
    rd(8'h08, 16'h00E0);
    rd(8'h0A, 16'h0000);
    rd(8'h20, 16'h0000);
    for (g = 16'h0000; g < 16'h0005; g++) begin
      wr(8'h08, g);
      rd(8'h08, 16'h00E0 | g);
      chk({13'h0000, gain_code}, g);
    end
    wr(8'h0C, 16'h0003);
    wr(8'h0A, 16'h000C);
    rd(8'h0A, 16'h003C);
    chkb(pretrigger_enable, 1'b1);
    wr(8'h0A, 16'h0000);
    wr(8'h0C, 16'h0000);
    wr(8'h06, 16'h0035);
    chk({8'h00, expansion_channel, mux_channel_bits}, 16'h0035);
    rd(8'h06, 16'h0005);
    conv(16'h0ABC, 4'h1);
    rd(8'h00, 16'hABC5);
    chk({14'h0000, bus_irq, first_interrupt}, 16'h0003);
    wr(8'h48, 16'h0000);
    chk({14'h0000, bus_irq, first_interrupt}, 16'h0000);
    @(posedge core_clk) variant_16bit <= 1'b1;
    conv(16'hBEEF, 4'h6);
    rd(8'h00, 16'hBEEF);
    @(posedge core_clk) variant_16bit <= 1'b0;
    wr(8'h06, 16'h0002);
    wr(8'h0A, 16'h0001);
    cur = 4'h0;
    for (k = 0; k < 4; k++) begin
      conv(16'h0123, 4'h2);
      rd(8'h00, {12'h123, cur});
      cur = (cur == 4'h2) ? 4'h0 : cur + 4'h1;
      rd(8'h06, {8'h00, cur, 4'h2});
    end
    wr(8'h0A, 16'h0000);
    rd(8'h06, 16'h0002);
    wr(8'h48, 16'h0000);
    wr(8'h0C, 16'h0001);
    for (k = 1; k <= 8; k++) begin
      conv(16'h0456, 4'h0);
      rd(8'h08, (k == 8) ? 16'h0094 : (k >= 4) ? 16'h00D4 : 16'h00F4);
      chkb(first_interrupt, k >= 4);
    end
    // full FIFO stalls the sequencer, so busy stays low
    wr(8'h0E, 16'h0000);
    rd(8'h08, 16'h0014);
    wr(8'h0C, 16'h0004);
    wr(8'h0C, 16'h0000);
    rd(8'h08, 16'h00E4);
    wr(8'h0C, 16'h0002);
    wr(8'h48, 16'h0000);
    wr(8'h0A, 16'h0004);
    @(posedge core_clk) external_trigger_in <= 1'b1;
    @(posedge core_clk) external_trigger_in <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    chkb(second_interrupt, 1'b1);
    wr(8'h48, 16'h0000);
    chkb(second_interrupt, 1'b0);
    rd(8'h00, 16'h4562);
    wr(8'h0A, 16'h0002);
    wr(8'h0C, 16'h0000);
    @(posedge core_clk) pacer_tick <= 1'b1;
    @(posedge core_clk) pacer_tick <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chkb(second_interrupt, 1'b1);
    rd(8'h00, 16'h4562);
    wr(8'h0A, 16'h0000);
    wr(8'h48, 16'h0000);
    chkb(bus_irq, 1'b0);
    @(posedge core_clk) ext_mode <= 2'h2;
    extended_input_lines <= 4'h5;
    wr(8'h04, 16'h000A);
    chk({11'h000, extended_output_oe, extended_output_lines}, 16'h001A);
    rd(8'h04, 16'h00A5);
    @(posedge core_clk) ext_mode <= 2'h3;
    wr(8'h06, 16'h0070);
    chk({11'h000, extended_output_oe, extended_output_lines}, 16'h0017);
    @(posedge core_clk) ext_mode <= 2'h1;
    @(posedge core_clk);
    #1;
    chkb(extended_output_oe, 1'b0);
    test_done;
  end
endmodule
`default_nettype wire
